/* File: bench/itc_tb_top.sv */
// Purpose: Self-checking bench for the invalidate command block
// Assumes: Word, halfword and byte transfers; bench answers the flush and cache handshakes itself
// Notes: Expected values come from a small register model kept in the bench
`timescale 1ns/1ps
`include "itc_regs.svh"
module itc_tb_top;
   localparam logic [11:0] CMD_HI = `ITC_OFS_ADDR_LO + 12'h008 + 12'h004;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic wbf_req, wbf_done, inv_req, inv_done, flush_strap;
   logic [31:0] haddr, hwdata, hrdata, rng, m_cmd, m_ctrl, lanes;
   logic [1:0] htrans, inv_gran;
   logic [2:0] hsize, wsize;
   logic [15:0] inv_domain;
   logic [63:0] inv_addr, m_addr;
   int mismatches, checked;
   assign hready = hreadyout;
   itc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .write_buffer_flush_required(flush_strap), .wbf_req(wbf_req), .wbf_done(wbf_done),
      .inv_req(inv_req), .inv_gran(inv_gran), .inv_domain(inv_domain),
      .inv_addr(inv_addr), .inv_done(inv_done));
   function logic [31:0] xorshift();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xorshift
   function logic [31:0] model_read(input logic [11:0] a);
      case (a)
         `ITC_OFS_CAP_LO: return 32'(flush_strap) << `ITC_CAP_WBF_BIT;
         // Location field counts 16-byte units
         `ITC_OFS_XCAP_LO: return 32'(`ITC_OFS_ADDR_LO >> 4) << `ITC_XCAP_OFS_LSB;
         `ITC_OFS_CTRL: return m_ctrl;
         `ITC_OFS_ADDR_LO: return m_addr[31:0];
         `ITC_OFS_ADDR_HI: return m_addr[63:32];
         CMD_HI: return m_cmd;
         default: return 32'h0000_0000;
      endcase
   endfunction : model_read
   function logic [1:0] exp_gran();
      if (m_ctrl[0] || m_cmd[29:28] == `ITC_GRAN_RSVD) return `ITC_GRAN_GLOBAL;
      return m_cmd[29:28];
   endfunction : exp_gran
   task chk_reg(input logic [11:0] a, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error reg %h expected %h seen %h", a, e, g);
      end
   endtask : chk_reg
   task chk_port(input string n, input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk_port
   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic rdy;
      logic rsp;
      logic [11:0] aw;
      logic [31:0] q;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= wsize;
      do begin
         @(negedge hclk);
         rdy = hreadyout;
         @(posedge hclk);
      end while (rdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(negedge hclk);
         rdy = hreadyout;
         rsp = hresp;
         q = hrdata;
         @(posedge hclk);
      end while (rdy !== 1'b1);
      chk_port("hresp", 64'h0, 64'(rsp));
      if (!wr) chk_reg(a, model_read(a), q);
      aw = {a[11:2], 2'b00};
      // Busy command word refuses writes; address word is always taken
      if (wr && aw == `ITC_OFS_ADDR_LO) m_addr[31:0] = d;
      if (wr && aw == `ITC_OFS_ADDR_HI) m_addr[63:32] = d;
      if (wr && aw == `ITC_OFS_CTRL) m_ctrl = d & 32'h0000_0001;
      // Only the written byte lanes of the command word change
      if (wr && aw == CMD_HI && !m_cmd[31])
         m_cmd = (d & lanes & 32'hB000_FFFF) | (m_cmd & ~(lanes & 32'hB000_FFFF));
   endtask : ahb
   task pulse(input bit flush);
      @(posedge hclk);
      if (flush) wbf_done <= 1'b1;
      else inv_done <= 1'b1;
      @(posedge hclk);
      wbf_done <= 1'b0;
      inv_done <= 1'b0;
      @(negedge hclk);
   endtask : pulse
   task run_inval(input logic [1:0] g, input logic [11:0] a);
      logic [31:0] d;
      logic [1:0] eg;
      d = xorshift();
      d[31:28] = {2'b11, g};
      ahb(1'b1, a, d);
      wsize = 3'h2;
      lanes = 32'hFFFF_FFFF;
      @(negedge hclk);
      chk_port("wbf_req", 64'(flush_strap), 64'(wbf_req));
      chk_port("inv_req", 64'(!flush_strap), 64'(inv_req));
      if (flush_strap) begin
         pulse(1'b1);
         chk_port("inv_req", 64'h1, 64'(inv_req));
         chk_port("wbf_req", 64'h0, 64'(wbf_req));
      end
      eg = exp_gran();
      chk_port("inv_gran", 64'(eg), 64'(inv_gran));
      chk_port("inv_domain", 64'(m_cmd[15:0]), 64'(inv_domain));
      ahb(1'b0, CMD_HI, 32'h0);
      ahb(1'b1, CMD_HI, xorshift() ^ 32'h8000_0000);
      ahb(1'b0, CMD_HI, 32'h0);
      repeat (int'(xorshift() & 32'h3)) @(posedge hclk);
      chk_port("inv_req", 64'h1, 64'(inv_req));
      pulse(1'b0);
      chk_port("inv_req", 64'h0, 64'(inv_req));
      m_cmd[31] = 1'b0;
      m_cmd[26:25] = eg;
      ahb(1'b0, CMD_HI, 32'h0);
   endtask : run_inval
   task print_verdict();
      $display("Comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      repeat (5000) @(posedge hclk);
      mismatches++;
      print_verdict();
   end
   initial begin
      rng = 32'd76;
      {hresetn, hsel, hwrite, wbf_done, inv_done, flush_strap} = 6'h00;
      {haddr, hwdata, htrans, hsize} = '0;
      {m_addr, m_cmd, m_ctrl, mismatches, checked} = '0;
      wsize = 3'h2;
      lanes = 32'hFFFF_FFFF;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, read-only words and four unmapped words
      for (int a = 0; a < 12'h210; a += 4) begin
         if (a < 12'h014 || a >= 12'h100) ahb(1'b0, 12'(a), 32'h0);
         if (a == 12'h10C) a = 12'h1FC;
      end
      chk_port("inv_req", 64'h0, 64'(inv_req));
      // Address written while idle and read back; capability write ignored
      ahb(1'b1, `ITC_OFS_ADDR_LO, xorshift());
      ahb(1'b1, `ITC_OFS_ADDR_HI, xorshift());
      ahb(1'b1, `ITC_OFS_CAP_LO, 32'hFFFF_FFFF);
      ahb(1'b0, `ITC_OFS_ADDR_LO, 32'h0);
      ahb(1'b0, `ITC_OFS_ADDR_HI, 32'h0);
      chk_port("inv_addr", m_addr, inv_addr);
      for (int s = 0; s < 2; s++) begin
         @(posedge hclk) flush_strap <= 1'(s);
         ahb(1'b0, `ITC_OFS_CAP_LO, 32'h0);
         for (int g = 0; g < 6; g++) begin
            // Case four forces a coarser global run of a domain request
            if (g == 4) ahb(1'b1, `ITC_OFS_CTRL, 32'h0000_0001);
            // Case five: halfword misses lane 3, then a lone lane 3 byte triggers
            if (g == 5) begin
               wsize = 3'h1;
               lanes = 32'h0000_FFFF;
               ahb(1'b1, CMD_HI, xorshift() | 32'h8000_0000);
               @(negedge hclk);
               chk_port("wbf_req|inv_req", 64'h0, 64'(inv_req | wbf_req));
               wsize = 3'h0;
               lanes = 32'hFF00_0000;
            end
            run_inval(g == 4 ? `ITC_GRAN_DOMAIN : 2'(g),
               g == 5 ? CMD_HI + 12'h003 : CMD_HI);
            if (g == 4) ahb(1'b1, `ITC_OFS_CTRL, 32'h0000_0000);
         end
      end
      print_verdict();
   end
endmodule : itc_tb_top

/* File: rtl/itc_pkg.sv */
// Purpose: Types of the translation cache invalidate block
// Assumes: Constants come from itc_regs.svh
// Notes: One packed struct holds all state of the top module except the two address words
package itc_pkg;

   typedef enum logic [1:0] {
      ITC_IDLE = 2'b00,
      ITC_FLUSH = 2'b01,
      ITC_INVAL = 2'b10
   } itc_state_t;

   typedef struct packed {
      itc_state_t state;
      logic trigger;
      logic [1:0] req_gran;
      logic [1:0] act_gran;
      logic [1:0] exec_gran;
      logic [15:0] domain;
      logic force_global;
      logic wr_pend;
      logic [11:0] waddr;
      logic [3:0] wbe;
      logic [31:0] rdata;
   } itc_st_t;

endpackage : itc_pkg

/* File: rtl/itc_regs.svh */
// Purpose: Offsets, field positions and codes of the translation cache invalidate block
// Assumes: 32-bit AHB-Lite words, 64-bit registers split into low and high words
// Notes: Decode uses address bits 11:0 only
`ifndef ITC_REGS_SVH
`define ITC_REGS_SVH

`define ITC_AW 12
`define ITC_OFS_CAP_LO 12'h000
`define ITC_OFS_CAP_HI 12'h004
`define ITC_OFS_XCAP_LO 12'h008
`define ITC_OFS_XCAP_HI 12'h00C
`define ITC_OFS_CTRL 12'h010
`define ITC_OFS_ADDR_LO 12'h100
`define ITC_OFS_ADDR_HI 12'h104
`define ITC_CMD_STEP 12'h008
`define ITC_OFS_CMD_LO 12'h108
`define ITC_OFS_CMD_HI 12'h10C

// Capability low word
`define ITC_CAP_WBF_BIT 4
// Extended capability low word: address register location in 16-byte units
`define ITC_XCAP_OFS_LSB 8
`define ITC_XCAP_OFS_W 10
`define ITC_XCAP_OFS_VAL 10'h010
// Control register
`define ITC_CTRL_FORCE_BIT 0
// Command high word (bit 63 of the register is bit 31 here)
`define ITC_CMD_TRIG_BIT 31
`define ITC_CMD_RSVD_BIT 30
`define ITC_CMD_REQ_LSB 28
`define ITC_CMD_ACT_LSB 25
`define ITC_CMD_DOM_LSB 0

`define ITC_GRAN_RSVD 2'h0
`define ITC_GRAN_GLOBAL 2'h1
`define ITC_GRAN_DOMAIN 2'h2
`define ITC_GRAN_PAGE 2'h3

`define ITC_RST_WORD 32'h0000_0000

`endif

/* File: rtl/itc_top.sv */
// Purpose: AHB-Lite register front end that starts and tracks cache invalidations
// Assumes: One master, no wait states, cache and write buffer on the same clock
// Notes: Read data is sampled in the address phase
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "itc_regs.svh"
// How it works
// - Address and command are two 64-bit registers
// - Command register sits eight bytes above address
// - Extended capability publishes address register location
// - Upper command byte write with trigger starts invalidation
// - Trigger clears only after invalidation fully completes
// - Completion reports actually used granularity
// - Flush write buffer first when capability demands
// - Granularity codes reserved, global, domain, page
// - Coarser execution allowed when reported
module itc_top
   import itc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic write_buffer_flush_required,
   output logic wbf_req,
   input wire logic wbf_done,
   output logic inv_req,
   output logic [1:0] inv_gran,
   output logic [15:0] inv_domain,
   output logic [63:0] inv_addr,
   input wire logic inv_done
);
   itc_st_t st_q;
   itc_st_t st_d;
   logic ap_valid;
   logic [3:0] ap_be;
   logic [3:0] be_addr_lo;
   logic [3:0] be_addr_hi;
   logic [31:0] addr_lo;
   logic [31:0] addr_hi;
   logic [31:0] cmd_hi_rd;
   logic [31:0] cmd_hi_new;
   logic [31:0] wmask;
   logic start;
   logic [1:0] eff_gran;

   assign ap_valid = hsel && htrans[1] && hready;

   // Byte lanes of the address phase; anything above word size acts as word
   always_comb begin
      ap_be = 4'hF;
      if (hsize == 3'h0) begin
         ap_be = 4'h1 << haddr[1:0];
      end else if (hsize == 3'h1) begin
         ap_be = haddr[1] ? 4'hC : 4'h3;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{st_q.wbe[i]}};
      end
   end

   assign be_addr_lo = (st_q.wr_pend && st_q.waddr == `ITC_OFS_ADDR_LO) ? st_q.wbe : 4'h0;
   assign be_addr_hi = (st_q.wr_pend && st_q.waddr == `ITC_OFS_ADDR_HI) ? st_q.wbe : 4'h0;

   itc_word_reg u_addr_lo (
      .hclk(hclk),
      .hresetn(hresetn),
      .be(be_addr_lo),
      .wdata(hwdata),
      .q(addr_lo)
   );

   itc_word_reg u_addr_hi (
      .hclk(hclk),
      .hresetn(hresetn),
      .be(be_addr_hi),
      .wdata(hwdata),
      .q(addr_hi)
   );

   always_comb begin
      cmd_hi_rd = `ITC_RST_WORD;
      cmd_hi_rd[`ITC_CMD_TRIG_BIT] = st_q.trigger;
      cmd_hi_rd[`ITC_CMD_REQ_LSB +: 2] = st_q.req_gran;
      cmd_hi_rd[`ITC_CMD_ACT_LSB +: 2] = st_q.act_gran;
      cmd_hi_rd[`ITC_CMD_DOM_LSB +: 16] = st_q.domain;
   end

   assign cmd_hi_new = (cmd_hi_rd & ~wmask) | (hwdata & wmask);

   // Only the upper byte carries the trigger; busy writes are dropped whole
   assign start = st_q.wr_pend && st_q.waddr == `ITC_OFS_CMD_HI && st_q.wbe[3]
      && hwdata[`ITC_CMD_TRIG_BIT] && st_q.state == ITC_IDLE;

   // Reserved request and forced mode both fall back to global
   assign eff_gran = (st_q.force_global || cmd_hi_new[`ITC_CMD_REQ_LSB +: 2] == `ITC_GRAN_RSVD)
      ? `ITC_GRAN_GLOBAL : cmd_hi_new[`ITC_CMD_REQ_LSB +: 2];

   always_comb begin
      st_d = st_q;
      st_d.wr_pend = ap_valid && hwrite;
      // Word aligned so byte and halfword writes reach their register
      st_d.waddr = {haddr[11:2], 2'b00};
      st_d.wbe = ap_be;
      if (st_q.wr_pend) begin
         if (st_q.waddr == `ITC_OFS_CTRL && st_q.wbe[0]) begin
            st_d.force_global = hwdata[`ITC_CTRL_FORCE_BIT];
         end
         if (st_q.waddr == `ITC_OFS_CMD_HI && st_q.state == ITC_IDLE) begin
            // Bit 62 and the actual field are not stored from the bus
            st_d.req_gran = cmd_hi_new[`ITC_CMD_REQ_LSB +: 2];
            st_d.domain = cmd_hi_new[`ITC_CMD_DOM_LSB +: 16];
         end
      end
      case (st_q.state)
         ITC_IDLE: begin
            if (start) begin
               st_d.trigger = 1'b1;
               st_d.exec_gran = eff_gran;
               st_d.state = write_buffer_flush_required ? ITC_FLUSH : ITC_INVAL;
            end
         end
         ITC_FLUSH: begin
            if (wbf_done) begin
               st_d.state = ITC_INVAL;
            end
         end
         ITC_INVAL: begin
            if (inv_done) begin
               st_d.trigger = 1'b0;
               st_d.act_gran = st_q.exec_gran;
               st_d.state = ITC_IDLE;
            end
         end
         default: begin
            st_d.state = ITC_IDLE;
         end
      endcase
      st_d.rdata = `ITC_RST_WORD;
      if (ap_valid && !hwrite) begin
         case ({haddr[11:2], 2'b00})
            `ITC_OFS_CAP_LO: st_d.rdata[`ITC_CAP_WBF_BIT] = write_buffer_flush_required;
            `ITC_OFS_XCAP_LO: st_d.rdata[`ITC_XCAP_OFS_LSB +: `ITC_XCAP_OFS_W] =
               `ITC_XCAP_OFS_VAL;
            `ITC_OFS_CTRL: st_d.rdata[`ITC_CTRL_FORCE_BIT] = st_q.force_global;
            `ITC_OFS_ADDR_LO: st_d.rdata = addr_lo;
            `ITC_OFS_ADDR_HI: st_d.rdata = addr_hi;
            `ITC_OFS_CMD_HI: st_d.rdata = cmd_hi_rd;
            default: st_d.rdata = `ITC_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_q.rdata;
   assign wbf_req = st_q.state == ITC_FLUSH;
   assign inv_req = st_q.state == ITC_INVAL;
   assign inv_gran = st_q.exec_gran;
   assign inv_domain = st_q.domain;
   assign inv_addr = {addr_hi, addr_lo};

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_start_trigger: assert property (start |=> st_q.trigger && (wbf_req || inv_req))
      else $error("trigger write did not start an invalidation");
   a_flush_before: assert property ($rose(inv_req) && write_buffer_flush_required
      |-> $past(wbf_req) && $past(wbf_done))
      else $error("invalidation began without write buffer flush");
   a_no_flush_path: assert property (start && !write_buffer_flush_required
      |=> inv_req && !wbf_req)
      else $error("flush done although not required");
   a_trigger_holds: assert property (st_q.trigger && !(inv_req && inv_done)
      |=> st_q.trigger)
      else $error("trigger cleared before completion");
   a_trigger_clear: assert property (inv_req && inv_done |=> !st_q.trigger && !inv_req)
      else $error("trigger not cleared on completion");
   a_actual_report: assert property (inv_req && inv_done
      |=> st_q.act_gran == $past(inv_gran))
      else $error("actual granularity not reported");
   a_gran_legal: assert property (inv_req |-> inv_gran != `ITC_GRAN_RSVD
      && (!st_q.force_global || inv_gran == `ITC_GRAN_GLOBAL))
      else $error("executed granularity reserved or not coarsened");
   a_bit62_zero: assert property (ap_valid && !hwrite && haddr[11:0] == `ITC_OFS_CMD_HI
      |=> !hrdata[`ITC_CMD_RSVD_BIT] && hrdata[`ITC_CMD_TRIG_BIT] == $past(st_q.trigger))
      else $error("command read shows bit 62 set or wrong trigger");
   a_offset_field: assert property (ap_valid && !hwrite && haddr[11:0] == `ITC_OFS_XCAP_LO
      |=> hrdata[`ITC_XCAP_OFS_LSB +: `ITC_XCAP_OFS_W] == `ITC_XCAP_OFS_VAL)
      else $error("address register location field wrong");
   a_cmd_pair: assert property (ap_valid && !hwrite
      && haddr[11:0] == `ITC_OFS_ADDR_LO + `ITC_CMD_STEP + 12'h004
      |=> hrdata[`ITC_CMD_ACT_LSB +: 2] == $past(st_q.act_gran))
      else $error("command register not eight bytes above address");

   c_global_done: cover property (start && eff_gran == `ITC_GRAN_GLOBAL ##[1:20] inv_done);
   c_flush_path: cover property (wbf_req && wbf_done ##1 inv_req);
   c_page_request: cover property (start && eff_gran == `ITC_GRAN_PAGE);
   c_busy_write: cover property (st_q.wr_pend && st_q.waddr == `ITC_OFS_CMD_HI && st_q.trigger);
endmodule : itc_top

/* File: rtl/itc_word_reg.sv */
// Purpose: One 32-bit software register word with byte lane writes
// Assumes: Byte enables already decoded by the bus slave
// Notes: Reset value is all zero
`timescale 1ns/1ps
`include "itc_regs.svh"
module itc_word_reg (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] be,
   input wire logic [31:0] wdata,
   output logic [31:0] q
);
   logic [31:0] word_q;
   logic [31:0] word_d;

   always_comb begin
      word_d = word_q;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            word_d[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         word_q <= `ITC_RST_WORD;
      end else begin
         word_q <= word_d;
      end
   end

   assign q = word_q;
endmodule : itc_word_reg
